/* File: rtl/vpc_ctrl.sv */
/*
  Serial-bus slave and control register bank of a video pre-amp.
  Assumes scl/sda and video timing pins are asynchronous; sda is
  open drain, resolved outside from sda_oe_out.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vpc_params.svh"
module vpc_ctrl (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic hblank_in,
  input wire logic vblank_pin_in,
  input wire logic sandcastle_vblank_in,
  output logic [6:0] red_gain_out,
  output logic [6:0] blue_gain_out,
  output logic [6:0] green_gain_out,
  output logic [6:0] contrast_out,
  output logic [7:0] level_one_out,
  output logic [7:0] level_two_out,
  output logic [7:0] level_three_out,
  output logic [7:0] brightness_out,
  output logic [2:0] video_offset_out,
  output logic [1:0] overlay_contrast_out,
  output logic power_save_out,
  output logic bias_range_halve_out,
  output logic brightness_mix_enable_out,
  output logic overlay_only_out,
  output logic brightness_output_switch_out,
  output logic sandcastle_select_out,
  output logic clamp_polarity_out,
  output logic video_blank_out
);
  import vpc_pkg::*;

  // Reset value per offset
  function automatic vpc_byte_t rst_val(input logic [3:0] a);
    if (a <= `VPC_OFS_CONTRAST) rst_val = `VPC_RST_GAIN;
    else if (a <= `VPC_OFS_BRIGHT) rst_val = `VPC_RST_LEVEL;
    else if (a == `VPC_OFS_OFFSET) rst_val = `VPC_RST_OFFSET;
    else if (a == `VPC_OFS_GLOBAL) rst_val = `VPC_RST_GLOBAL;
    else if (a == `VPC_OFS_AUTO_INCREMENT_DISABLE) rst_val = `VPC_RST_AUTO_INCREMENT_DISABLE;
    else if (a == `VPC_OFS_CLAMP) rst_val = `VPC_RST_CLAMP;
    else rst_val = 8'h00;
  endfunction : rst_val

  // Implemented bits per offset
  function automatic vpc_byte_t bit_mask(input logic [3:0] a);
    if (a <= `VPC_OFS_CONTRAST) bit_mask = `VPC_MASK_GAIN;
    else if (a <= `VPC_OFS_BRIGHT) bit_mask = `VPC_MASK_LEVEL;
    else if (a == `VPC_OFS_OFFSET) bit_mask = `VPC_MASK_OFFSET;
    else if (a == `VPC_OFS_GLOBAL) bit_mask = `VPC_MASK_GLOBAL;
    else if (a == `VPC_OFS_AUTO_INCREMENT_DISABLE) bit_mask = `VPC_MASK_AUTO_INCREMENT_DISABLE;
    else if (a == `VPC_OFS_CLAMP) bit_mask = `VPC_MASK_CLAMP;
    else bit_mask = 8'h00;
  endfunction : bit_mask

  // Synchronised pins
  logic [4:0] pins_s;
  logic scl_s, sda_s, hbl_s, vpin_s, vsc_s;
  // Previous bus levels for edges
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  // Serial engine state
  vpc_state_t state_q;
  logic [3:0] cnt_q;
  vpc_byte_t shift_q;
  vpc_byte_t tx_q;
  logic [7:0] ptr_q;
  logic wr_stb_q;
  logic [7:0] wr_addr_q;
  vpc_byte_t wr_data_q;
  // Register bank and soft reset
  vpc_byte_t regs_q [16];
  logic soft_reset_bit_q;
  vpc_byte_t rd_q;
  // Selected vertical pulse
  logic vert_now;

  vpc_sync #(
    .W(5)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in({scl_in, sda_in, hblank_in, vblank_pin_in,
      sandcastle_vblank_in}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s, hbl_s, vpin_s, vsc_s} = pins_s;

  // Edge history of bus lines
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Open drain data never drives high
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) sda_out <= 1'b0;
    else sda_out <= 1'b0;
  end

  // Serial slave engine; soft reset leaves it alone
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_out <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det) begin
        // Start or repeated start
        state_q <= ST_DEV;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          // Sample a bit on rising clock
          ST_DEV, ST_REG, ST_WR: begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          ST_RD: begin
            cnt_q <= cnt_q + 4'h1;
          end
          // Master not acknowledging ends read
          ST_MACK: begin
            if (sda_s) state_q <= ST_IDLE;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_DEV: begin
            if (cnt_q == 4'h8) begin
              if (shift_q[7:1] == `VPC_DEV_ADDR) begin
                sda_oe_out <= 1'b1;
                state_q <= ST_DACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_DACK: begin
            cnt_q <= 4'h0;
            if (shift_q[0]) begin
              tx_q <= rd_q;
              sda_oe_out <= ~rd_q[7];
              state_q <= ST_RD;
            end else begin
              sda_oe_out <= 1'b0;
              state_q <= ST_REG;
            end
          end
          ST_REG: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= shift_q;
              sda_oe_out <= 1'b1;
              state_q <= ST_RACK;
            end
          end
          ST_RACK, ST_WACK: begin
            sda_oe_out <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= ST_WR;
          end
          ST_WR: begin
            if (cnt_q == 4'h8) begin
              wr_stb_q <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= shift_q;
              sda_oe_out <= 1'b1;
              state_q <= ST_WACK;
              if (!regs_q[`VPC_OFS_AUTO_INCREMENT_DISABLE][`VPC_BIT_INCDIS]) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= ST_MACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_out <= ~tx_q[6];
            end
          end
          ST_MACK: begin
            tx_q <= rd_q;
            sda_oe_out <= ~rd_q[7];
            cnt_q <= 4'h0;
            state_q <= ST_RD;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) rd_q <= 8'h00;
    else if (ptr_q[7:4] != 4'h0) rd_q <= 8'h00;
    else rd_q <= regs_q[ptr_q[3:0]] & bit_mask(ptr_q[3:0]);
  end

  // Soft reset request, self clearing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_bit_q <= 1'b0;
    end else if (soft_reset_bit_q) begin
      soft_reset_bit_q <= 1'b0;
    end else if (wr_stb_q && wr_addr_q == {4'h0, `VPC_OFS_SOFT_RESET_BIT}) begin
      soft_reset_bit_q <= wr_data_q[`VPC_BIT_SOFT_RESET_BIT];
    end
  end

  // Register bank, one entry per offset
  for (genvar i = 0; i < 16; i++) begin : g_reg
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        regs_q[i] <= rst_val(4'(i));
      end else if (soft_reset_bit_q) begin
        regs_q[i] <= rst_val(4'(i));
      end else if (wr_stb_q && wr_addr_q == 8'(i)) begin
        regs_q[i] <= wr_data_q & bit_mask(4'(i));
      end
    end
  end

  assign vert_now = regs_q[`VPC_OFS_CLAMP][`VPC_BIT_SWITCH] ? vsc_s
    : vpin_s;

  // Static control outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      red_gain_out <= 7'h60;
      blue_gain_out <= 7'h60;
      green_gain_out <= 7'h60;
      level_one_out <= `VPC_RST_LEVEL;
      level_two_out <= `VPC_RST_LEVEL;
      level_three_out <= `VPC_RST_LEVEL;
      video_offset_out <= 3'h5;
      overlay_contrast_out <= 2'h2;
      power_save_out <= 1'b0;
      bias_range_halve_out <= 1'b0;
      brightness_mix_enable_out <= 1'b0;
      overlay_only_out <= 1'b0;
      brightness_output_switch_out <= 1'b1;
      sandcastle_select_out <= 1'b0;
      clamp_polarity_out <= 1'b0;
    end else begin
      red_gain_out <= regs_q[`VPC_OFS_RED][6:0];
      blue_gain_out <= regs_q[`VPC_OFS_BLUE][6:0];
      green_gain_out <= regs_q[`VPC_OFS_GREEN][6:0];
      level_one_out <= regs_q[`VPC_OFS_LEVEL1];
      level_two_out <= regs_q[`VPC_OFS_LEVEL2];
      level_three_out <= regs_q[`VPC_OFS_LEVEL3];
      video_offset_out <= regs_q[`VPC_OFS_OFFSET][2:0];
      overlay_contrast_out <= regs_q[`VPC_OFS_OFFSET][4:3];
      power_save_out <= regs_q[`VPC_OFS_GLOBAL][`VPC_BIT_PSAVE];
      bias_range_halve_out <= regs_q[`VPC_OFS_GLOBAL][`VPC_BIT_HALVE];
      brightness_mix_enable_out <= regs_q[`VPC_OFS_GLOBAL][`VPC_BIT_MIX];
      overlay_only_out <= regs_q[`VPC_OFS_CLAMP][`VPC_BIT_OVLONLY];
      brightness_output_switch_out <=
        regs_q[`VPC_OFS_CLAMP][`VPC_BIT_SWITCH];
      sandcastle_select_out <= regs_q[`VPC_OFS_CLAMP][`VPC_BIT_SWITCH]
        & regs_q[`VPC_OFS_CLAMP][`VPC_BIT_VBLEN];
      clamp_polarity_out <= regs_q[`VPC_OFS_CLAMP][`VPC_BIT_CLAMP];
    end
  end

  // Deferred contrast and brightness
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      contrast_out <= 7'h60;
      brightness_out <= `VPC_RST_LEVEL;
    end else if (!regs_q[`VPC_OFS_CLAMP][`VPC_BIT_VBLEN] || vert_now) begin
      contrast_out <= regs_q[`VPC_OFS_CONTRAST][6:0];
      brightness_out <= regs_q[`VPC_OFS_BRIGHT];
    end
  end

  // Output blanking
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      video_blank_out <= 1'b0;
    end else begin
      video_blank_out <= regs_q[`VPC_OFS_GLOBAL][`VPC_BIT_BLANK]
        | regs_q[`VPC_OFS_CLAMP][`VPC_BIT_OVLONLY] | hbl_s
        | (regs_q[`VPC_OFS_CLAMP][`VPC_BIT_VBLEN] & vert_now);
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_soft_reset_bit_clears: assert property (
    soft_reset_bit_q |=> !soft_reset_bit_q
  ) else $error("soft reset bit did not clear");
  a_soft_reset_bit_defaults: assert property (
    soft_reset_bit_q |=> regs_q[`VPC_OFS_CLAMP] == `VPC_RST_CLAMP
      && regs_q[`VPC_OFS_RED] == `VPC_RST_GAIN
  ) else $error("soft reset did not reload defaults");
  a_soft_reset_bit_bus_kept: assert property (
    soft_reset_bit_q && !start_det && !stop_det && !scl_rise && !scl_fall
      |=> state_q == $past(state_q)
  ) else $error("soft reset disturbed serial engine");
  a_reserved_zero: assert property (
    (regs_q[`VPC_OFS_RED][7] == 1'b0)
      && (regs_q[`VPC_OFS_CLAMP][7:4] == 4'h0)
  ) else $error("reserved bit stored");
  a_defer_hold: assert property (
    regs_q[`VPC_OFS_CLAMP][`VPC_BIT_VBLEN] && !vert_now
      |=> $stable(contrast_out)
  ) else $error("contrast changed outside retrace");
  a_blank_bit: assert property (
    regs_q[`VPC_OFS_GLOBAL][`VPC_BIT_BLANK] |=> video_blank_out
  ) else $error("video not blanked");
  a_vert_or: assert property (
    regs_q[`VPC_OFS_CLAMP][`VPC_BIT_VBLEN] && vert_now |=> video_blank_out
  ) else $error("vertical blank not applied");
  a_halve_follow: assert property (
    ##1 bias_range_halve_out == $past(regs_q[`VPC_OFS_GLOBAL][3])
  ) else $error("range bit not forwarded");
  a_addr_nack: assert property (
    state_q == ST_DEV && cnt_q == 4'h8 && scl_fall
      && shift_q[7:1] != `VPC_DEV_ADDR |=> !sda_oe_out
  ) else $error("acknowledged foreign address");
  a_auto_increment_disable_step: assert property (
    state_q == ST_WR && cnt_q == 4'h8 && scl_fall && !start_det
      && !stop_det && !regs_q[`VPC_OFS_AUTO_INCREMENT_DISABLE][0]
      |=> ptr_q == $past(ptr_q) + 8'h01
  ) else $error("write pointer not advanced");

  c_write: cover property (wr_stb_q);
  c_read: cover property (state_q == ST_RD ##[1:200] state_q == ST_MACK);
  c_soft_reset_bit: cover property (soft_reset_bit_q);
  c_defer: cover property (regs_q[`VPC_OFS_CLAMP][1] && vert_now);
endmodule : vpc_ctrl
`default_nettype wire

/* File: rtl/vpc_params.svh */
/*
  Offsets, field positions, reset values and masks of the video
  pre-amp control register bank.
  Assumes it is included by bare name from the control module.
*/
// Functional notes
// - Three 7-bit colour gains, reset 60h
// - 7-bit contrast scales all channels
// - Four 8-bit converter levels, reset 80h
// - 3-bit video DC offset, reset 5h
// - Overlay contrast field at bits 4-3
// - Blank video bit blanks output
// - Power save bit shuts analog circuits
// - Range bit halves converters one-three
// - Mix bit adds half brightness level
// - Increment bit zero advances write address
// - Overlay-only bit blanks video
// - Vertical blank ORed with horizontal blank
// - Contrast, brightness deferred to vertical retrace
// - Switch bit selects output or vertical input
// - Both bits select sandcastle vertical blank
// - Clamp polarity bit selects edge sense
// - Soft reset reloads all other registers
// - Soft reset spares serial transaction
// - Soft reset bit clears itself
// - Device address DCh write, DDh read
// - Read from written pointer, incrementing
`ifndef VPC_PARAMS_SVH
`define VPC_PARAMS_SVH
`define VPC_DEV_ADDR 7'h6e
`define VPC_OFS_RED 4'h0
`define VPC_OFS_BLUE 4'h1
`define VPC_OFS_GREEN 4'h2
`define VPC_OFS_CONTRAST 4'h3
`define VPC_OFS_LEVEL1 4'h4
`define VPC_OFS_LEVEL2 4'h5
`define VPC_OFS_LEVEL3 4'h6
`define VPC_OFS_BRIGHT 4'h7
`define VPC_OFS_OFFSET 4'h8
`define VPC_OFS_GLOBAL 4'h9
`define VPC_OFS_AUTO_INCREMENT_DISABLE 4'ha
`define VPC_OFS_CLAMP 4'hb
`define VPC_OFS_SOFT_RESET_BIT 4'hf
`define VPC_RST_GAIN 8'h60
`define VPC_RST_LEVEL 8'h80
`define VPC_RST_OFFSET 8'h15
`define VPC_RST_GLOBAL 8'h00
`define VPC_RST_AUTO_INCREMENT_DISABLE 8'h00
`define VPC_RST_CLAMP 8'h04
`define VPC_MASK_GAIN 8'h7f
`define VPC_MASK_LEVEL 8'hff
`define VPC_MASK_OFFSET 8'h1f
`define VPC_MASK_GLOBAL 8'h3f
`define VPC_MASK_AUTO_INCREMENT_DISABLE 8'h03
`define VPC_MASK_CLAMP 8'h0f
`define VPC_MASK_SOFT_RESET_BIT 8'h01
`define VPC_BIT_BLANK 0
`define VPC_BIT_PSAVE 1
`define VPC_BIT_HALVE 3
`define VPC_BIT_MIX 4
`define VPC_BIT_INCDIS 0
`define VPC_BIT_OVLONLY 0
`define VPC_BIT_VBLEN 1
`define VPC_BIT_SWITCH 2
`define VPC_BIT_CLAMP 3
`define VPC_BIT_SOFT_RESET_BIT 0
`endif

/* File: rtl/vpc_pkg.sv */
/*
  Types of the video pre-amp control block.
  Assumes vpc_params.svh sits on the include path.
*/
package vpc_pkg;
  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DACK, ST_REG, ST_RACK, ST_WR, ST_WACK, ST_RD,
    ST_MACK
  } vpc_state_t;
  // One register byte
  typedef logic [7:0] vpc_byte_t;
endpackage : vpc_pkg

/* File: rtl/vpc_sync.sv */
/*
  Two-flop synchroniser for a bundle of asynchronous pins.
  Assumes each bit is an independent level from outside the domain.
*/
`timescale 1ns/1ps
`default_nettype none
module vpc_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // One pair of flops per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_q[i] <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule : vpc_sync
`default_nettype wire

/* File: sim/testbench.sv */
/*
  Self-checking bench of the control register bank over the serial bus.
  Assumes the host model in vpc_host_model.sv and the rtl include path.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vpc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hblank_in = 1'b0;
  logic vblank_pin_in = 1'b0;
  logic sandcastle_vblank_in = 1'b0;
  logic scl, host_low, dut_sda, dut_oe, sda_lvl;
  logic [6:0] red_g, blue_g, green_g, contr;
  logic [7:0] lv1, lv2, lv3, bright;
  logic [2:0] voff;
  logic [1:0] ovc;
  logic psave, halve, mix, ovl, sw, sand, clamp, blank;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Register contents expected after any kind of reset
  vpc_byte_t rst_tab [16] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h80, 8'h80,
    8'h80, 8'h80, 8'h15, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  // Pull-up resolves the open-drain data line
  assign sda_lvl = ~(host_low | (dut_oe & ~dut_sda));
  always #5 ref_clk_in = ~ref_clk_in;
  vpc_host_model i_host (.ref_clk_in(ref_clk_in), .sda_in(sda_lvl),
    .scl_out(scl), .sda_low_out(host_low));
  vpc_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda_lvl), .sda_out(dut_sda),
    .sda_oe_out(dut_oe), .hblank_in(hblank_in),
    .vblank_pin_in(vblank_pin_in),
    .sandcastle_vblank_in(sandcastle_vblank_in),
    .red_gain_out(red_g), .blue_gain_out(blue_g),
    .green_gain_out(green_g), .contrast_out(contr),
    .level_one_out(lv1), .level_two_out(lv2), .level_three_out(lv3),
    .brightness_out(bright), .video_offset_out(voff),
    .overlay_contrast_out(ovc), .power_save_out(psave),
    .bias_range_halve_out(halve), .brightness_mix_enable_out(mix),
    .overlay_only_out(ovl), .brightness_output_switch_out(sw),
    .sandcastle_select_out(sand), .clamp_polarity_out(clamp),
    .video_blank_out(blank));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Byte comparison
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  // Single-bit comparison
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Sends one byte and expects the device to acknowledge it
  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    logic ack;
    i_host.xfer(b, 1'b1, rx, ack);
    chk_bit(ack, 1'b1);
  endtask : send
  // Single register write
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_host.start_cond();
    send(8'hdc);
    send(ofs);
    send(d);
    i_host.stop_cond();
  endtask : wr
  // Pointer write, then a read burst compared with a table
  task automatic rd(input logic [7:0] ofs, input int n,
                    input vpc_byte_t exp [16]);
    logic [7:0] rx;
    logic ack;
    i_host.start_cond();
    send(8'hdc);
    send(ofs);
    i_host.stop_cond();
    i_host.start_cond();
    send(8'hdd);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'hff, (i == n - 1), rx, ack);
      chk_byte(rx, exp[i]);
    end
    i_host.stop_cond();
  endtask : rd
  // Settles outputs after a pin change
  task automatic settle();
    repeat (6) @(negedge ref_clk_in);
  endtask : settle
  // Hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $time);
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    vpc_byte_t e [16];
    logic [7:0] rx;
    logic ack;
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    rd(8'h00, 16, rst_tab);
    chk_byte({1'b0, red_g}, 8'h60);
    chk_byte({1'b0, contr}, 8'h60);
    chk_byte({5'h00, voff}, 8'h05);
    chk_byte({6'h00, ovc}, 8'h02);
    chk_bit(sw, 1'b1);
    // Foreign address is left unanswered
    i_host.start_cond();
    i_host.xfer(8'ha0, 1'b1, rx, ack);
    chk_bit(ack, 1'b0);
    i_host.stop_cond();
    // Burst into the gains, reserved top bit dropped
    i_host.start_cond();
    send(8'hdc);
    send(8'h00);
    for (int i = 0; i < 4; i++) send(8'hff);
    i_host.stop_cond();
    e = '{default: 8'h7f};
    rd(8'h00, 4, e);
    chk_byte({blue_g, green_g[0]}, 8'hff);
    chk_byte({1'b0, contr}, 8'h7f);
    wr(8'h08, 8'hff);
    chk_byte({3'h0, ovc, voff}, 8'h1f);
    // Global control bits, must-zero bits left clear
    wr(8'h09, 8'h1b);
    chk_byte({4'h0, mix, halve, psave, blank}, 8'h0f);
    wr(8'h09, 8'h00);
    chk_byte({4'h0, mix, halve, psave, blank}, 8'h00);
    // Non-incrementing writes land on one register
    wr(8'h0a, 8'h01);
    i_host.start_cond();
    send(8'hdc);
    send(8'h04);
    send(8'h11);
    send(8'h22);
    i_host.stop_cond();
    e[0] = 8'h22;
    e[1] = 8'h80;
    rd(8'h04, 2, e);
    chk_byte(lv1, 8'h22);
    // Vertical gating from the shared pin, negative clamp
    wr(8'h0b, 8'h0a);
    chk_byte({clamp, sw, sand, ovl}, 8'h08);
    chk_bit(blank, 1'b0);
    wr(8'h03, 8'h11);
    wr(8'h07, 8'h33);
    chk_byte({1'b0, contr}, 8'h7f);
    chk_byte(bright, 8'h80);
    vblank_pin_in = 1'b1;
    settle();
    chk_bit(blank, 1'b1);
    chk_byte({1'b0, contr}, 8'h11);
    chk_byte(bright, 8'h33);
    vblank_pin_in = 1'b0;
    hblank_in = 1'b1;
    settle();
    chk_bit(blank, 1'b1);
    hblank_in = 1'b0;
    settle();
    chk_bit(blank, 1'b0);
    wr(8'h0b, 8'h01);
    chk_bit(ovl, 1'b1);
    chk_bit(blank, 1'b1);
    // Sandcastle source, clamp kept positive
    wr(8'h0b, 8'h06);
    chk_bit(sand, 1'b1);
    sandcastle_vblank_in = 1'b1;
    settle();
    chk_bit(blank, 1'b1);
    sandcastle_vblank_in = 1'b0;
    // Soft reset mid-burst, transfer carries on
    i_host.start_cond();
    send(8'hdc);
    send(8'h0f);
    send(8'h01);
    send(8'h00);
    i_host.stop_cond();
    rd(8'h00, 16, rst_tab);
    chk_byte({1'b0, red_g}, 8'h60);
    chk_byte(bright, 8'h80);
    chk_byte(lv2, 8'h80);
    chk_byte(lv3, 8'h80);
    chk_bit(clamp, 1'b0);
    chk_bit(dut_sda, 1'b0);
    chk_bit(blank, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

/* File: sim/vpc_host_model.sv */
/*
  Serial-bus master model that drives the control bank's scl and sda.
  Assumes sda has a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module vpc_host_model (
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // 80 ns half period of the 160 ns link clock
  localparam int HALF = 8;
  // Idle bus, link clock stands high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Waits whole reference cycles, driving off the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : tick
  task automatic start_cond();
    sda_low_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(4);
  endtask : start_cond
  // Data rises while clock high
  task automatic stop_cond();
    sda_low_out = 1'b1;
    tick(HALF - 4);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b0;
    tick(HALF);
  endtask : stop_cond
  // Data changes only well after the clock fell, to avoid false frames
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    tick(HALF - 4);
    scl_out = 1'b1;
    tick(HALF);
    r = sda_in;
    scl_out = 1'b0;
    tick(4);
  endtask : bit_io
  // bytes MSB first, ninth bit is acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ninth,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ninth, r);
    ack = ~r;
  endtask : xfer
endmodule : vpc_host_model
`default_nettype wire
